// ==== clkdiv_pkg.sv ====
// constants, tables and state encodings for the strap-configured clock divider
package clkdiv_pkg;

  // ------------------------------------------------------------------
  // strap levels and output standards
  // ------------------------------------------------------------------
  localparam logic [1:0] LVL_ZERO  = 2'h0;   // ground
  localparam logic [1:0] LVL_THIRD = 2'h1;   // 1/3 supply, also an open pin
  localparam logic [1:0] LVL_TWO3  = 2'h2;   // 2/3 supply
  localparam logic [1:0] LVL_ONE   = 2'h3;   // full supply
  localparam logic [1:0] STD_OFF   = 2'h0;   // output switched off
  localparam logic [1:0] STD_LVDS  = 2'h1;   // differential standard
  localparam logic [1:0] STD_CMOS  = 2'h2;   // single-ended standard

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int         CLK_PERIOD_NS      = 40;  // input clock period
  localparam int         SYNC_MIN_LOW_NS    = 5;   // least request low time
  localparam int         SYNC_MIN_LOW_RAW   =
    (SYNC_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;  // request low time in clocks
  localparam int         SYNC_MIN_LOW_CYC   = (SYNC_MIN_LOW_RAW < 1) ? 1 : SYNC_MIN_LOW_RAW;
  localparam logic [2:0] WAIT_CYCLES        = 3'h4;  // clocks from release to restart
  localparam logic [5:0] RATIO_BYPASS       = 6'h01; // divide-by-1 code value

  // ------------------------------------------------------------------
  // lookup tables, index 0 at the right
  // ------------------------------------------------------------------
  localparam logic [15:0][5:0] DIV_TABLE = {6'h20, 6'h1e, 6'h18, 6'h12, 6'h10, 6'h0f,
                                            6'h0c, 6'h0a, 6'h09, 6'h08, 6'h06, 6'h05,
                                            6'h04, 6'h03, 6'h02, 6'h01};
  localparam logic [15:0][5:0] ALT_TABLE = {6'h1f, 6'h1d, 6'h1c, 6'h1b, 6'h1a, 6'h19,
                                            6'h17, 6'h16, 6'h15, 6'h14, 6'h13, 6'h11,
                                            6'h0e, 6'h0d, 6'h0b, 6'h07};
  // {first, second, third} standards indexed by {usage, standard}
  localparam logic [15:0][5:0] MODE_TABLE = {6'h22, 6'h11, 6'h21, 6'h12, 6'h08, 6'h02,
                                             6'h01, 6'h00, 6'h29, 6'h16, 6'h15, 6'h2a,
                                             6'h18, 6'h14, 6'h28, 6'h04};
  // third output delay full scale in picoseconds, indexed by range level
  localparam logic [3:0][13:0] FULL_SCALE_PS = {14'h2d50, 14'h1770, 14'h0708, 14'h0000};

  // ------------------------------------------------------------------
  // alignment sequencer
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    st_hold,
    st_wait,
    st_run
  } sync_state_t;

  localparam logic [2:0]  RST_SYNC_PIPE = 3'h0;   // request seen low until sampled
  localparam logic [32:0] RST_STRAP     = 33'h0;  // straps read as zero until sampled

endpackage : clkdiv_pkg

// ==== clock_divider_sync_setup.sv ====
// three-output strap-configured clock divider with sync alignment
`timescale 1ns/1ns
module clock_divider_sync_setup
  import clkdiv_pkg::*;
(
  input  wire logic       i_clk,                   // input clock, all logic
  input  wire logic       i_rst,                   // sync reset = power-on event
  input  wire logic       i_sync_request_n,        // low freezes, rising aligns
  input  wire logic [1:0] i_delay_range_pin,       // strap level code
  input  wire logic [1:0] i_output_standard_pin,   // strap level code
  input  wire logic [1:0] i_output_usage_pin,      // strap level code
  input  wire logic [1:0] i_fine_delay_low_pin,    // strap level code
  input  wire logic [1:0] i_fine_delay_high_pin,   // strap level code
  input  wire logic [1:0] i_shared_setting_a_low,  // strap level code
  input  wire logic [1:0] i_shared_setting_a_high, // strap level code
  input  wire logic [1:0] i_shared_setting_b_low,  // strap level code
  input  wire logic [1:0] i_shared_setting_b_high, // strap level code
  input  wire logic [1:0] i_shared_setting_c_low,  // strap level code
  input  wire logic [1:0] i_shared_setting_c_high, // strap level code
  input  wire logic [10:0] i_strap_open,           // per strap: pin left open
  output logic            o_first_clock_output,    // divided clock 0
  output logic            o_second_clock_output,   // divided clock 1
  output logic            o_third_clock_output,    // divided clock 2
  output logic [1:0]      o_first_standard,        // off / lvds / cmos
  output logic [1:0]      o_second_standard,       // off / lvds / cmos
  output logic [1:0]      o_third_standard,        // off / lvds / cmos
  output logic [1:0]      o_third_delay_range,     // full-scale select, 0 = bypass
  output logic [3:0]      o_third_fine_delay,      // sixteenths of full scale
  output logic [13:0]     o_third_delay_ps,        // resulting delay in ps
  output logic            o_aligned_run            // dividers released and running
);

  // ------------------------------------------------------------------
  // state record
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]        sync_pipe;   // three-stage request synchroniser
    logic              sync_q;      // accepted request level
    logic [2:0][32:0]  strap_pipe;  // three-stage strap synchroniser
    logic [32:0]       strap_q;     // accepted strap vector
    sync_state_t       st;          // alignment sequencer state
    logic [2:0]        wcnt;        // release wait counter
    logic [2:0][5:0]   ratio;       // decoded divide ratios
    logic [2:0][3:0]   phase;       // decoded phase offsets
    logic [2:0][1:0]   mode;        // decoded output standards
    logic [1:0]        range;       // third output delay range
    logic [3:0]        fine;        // third output fine delay
    logic [13:0]       delay_ps;    // third output delay
    logic [2:0][4:0]   cnt;         // divider position
    logic [2:0][3:0]   dly;         // phase countdown after release
    logic [2:0]        out;         // divided outputs
    logic              run;         // registered run flag
  } state_t;

  state_t      s;       // registered state
  state_t      next_s;  // next state
  logic [32:0] raw;     // straps as seen at the pins

  assign raw = {i_strap_open,
                i_shared_setting_c_high, i_shared_setting_c_low,
                i_shared_setting_b_high, i_shared_setting_b_low,
                i_shared_setting_a_high, i_shared_setting_a_low,
                i_fine_delay_high_pin,   i_fine_delay_low_pin,
                i_output_usage_pin,      i_output_standard_pin,
                i_delay_range_pin};

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic [10:0][1:0] lv;    // level of each strap, open folded in
    logic [32:0]      agree; // stages two and three match
    logic [1:0]       usage; // output usage strap
    logic [3:0]       code_a; // shared pair a
    logic [3:0]       code_b; // shared pair b
    logic [3:0]       code_c; // shared pair c
    logic [3:0]       code_f; // fine delay pair
    logic [17:0]      prod;  // full scale times sixteenths
    lv     = '0;
    agree  = '0;
    usage  = '0;
    code_a = '0;
    code_b = '0;
    code_c = '0;
    code_f = '0;
    prod   = '0;
    next_s = s;

    // pin synchronisers: a change counts once stages two and three agree
    next_s.sync_pipe = {s.sync_pipe[1:0], i_sync_request_n};
    if (s.sync_pipe[1] == s.sync_pipe[2]) begin
      next_s.sync_q = s.sync_pipe[2];
    end
    next_s.strap_pipe = {s.strap_pipe[1:0], raw};
    agree = ~(s.strap_pipe[1] ^ s.strap_pipe[2]);
    next_s.strap_q = (agree & s.strap_pipe[2]) | (~agree & s.strap_q);

    // strap levels, an open pin reads as the self-bias level
    for (int k = 0; k < 11; k++) begin
      lv[k] = s.strap_q[22 + k] ? LVL_THIRD : s.strap_q[2*k +: 2];
    end
    usage  = lv[2];
    code_f = {lv[4], lv[3]};   // high digit first
    code_a = {lv[6], lv[5]};
    code_b = {lv[8], lv[7]};
    code_c = {lv[10], lv[9]};

    // output standards from standard and usage straps
    {next_s.mode[0], next_s.mode[1], next_s.mode[2]} = MODE_TABLE[{usage, lv[1]}];

    // first output: pair c unless usage is 2/3
    next_s.ratio[0] = (usage != LVL_TWO3) ? DIV_TABLE[code_c] : RATIO_BYPASS;
    next_s.phase[0] = 4'h0;
    // second output: pair b divides unless usage is 1
    next_s.ratio[1] = (usage != LVL_ONE) ? DIV_TABLE[code_b] : RATIO_BYPASS;
    // second output phase from pair a when usage is 0
    next_s.phase[1] = (usage == LVL_ZERO) ? code_a : 4'h0;
    // third output divide: alternate table from pair c on usage 2/3, bypass on usage 0, else pair a
    if (usage == LVL_TWO3) begin
      next_s.ratio[2] = ALT_TABLE[code_c];
    end else if (usage != LVL_ZERO) begin
      next_s.ratio[2] = DIV_TABLE[code_a];
    end else begin
      next_s.ratio[2] = RATIO_BYPASS;
    end
    // third output phase: fine pair with delay bypassed, else pair b on usage 1, else zero
    if (lv[0] == LVL_ZERO) begin
      next_s.phase[2] = code_f;
    end else if (usage == LVL_ONE) begin
      next_s.phase[2] = code_b;
    end else begin
      next_s.phase[2] = 4'h0;
    end

    // analog delay setting for the third output
    next_s.range    = lv[0];
    next_s.fine     = (lv[0] != LVL_ZERO) ? code_f : 4'h0;
    prod            = 18'(FULL_SCALE_PS[lv[0]]) * 18'(next_s.fine);
    next_s.delay_ps = prod[17:4];

    // alignment sequencer; reset leaves it in hold for power-on alignment
    unique case (s.st)
      st_hold: begin
        // static hold until the request is released
        if (s.sync_q) begin
          next_s.st   = st_wait;
          next_s.wcnt = 3'h0;
        end
      end
      st_wait: begin
        // four input clocks after release
        if (!s.sync_q) begin
          next_s.st = st_hold;
        end else if (s.wcnt == WAIT_CYCLES - 3'h1) begin
          next_s.st = st_run;
        end else begin
          next_s.wcnt = s.wcnt + 3'h1;
        end
      end
      st_run: begin
        // a new request is accepted at any time
        if (!s.sync_q) begin
          next_s.st = st_hold;
        end
      end
      default: begin
        // an unused state code falls back to hold
        next_s.st = st_hold;
      end
    endcase
    next_s.run = (next_s.st == st_run);

    // the three dividers, all on the input clock
    for (int i = 0; i < 3; i++) begin
      if (s.mode[i] == STD_OFF) begin
        // disabled output: held low, kept out of alignment
        next_s.out[i] = 1'b0;
        next_s.cnt[i] = 5'h00;
        next_s.dly[i] = 4'h0;
      end else if (s.ratio[i] == RATIO_BYPASS) begin
        // bypass toggles on every input clock, sync has no effect
        next_s.out[i] = ~s.out[i];
        next_s.cnt[i] = 5'h00;
        next_s.dly[i] = 4'h0;
      end else if (s.st != st_run) begin
        // frozen at a static low, phase offset preloaded
        next_s.out[i] = 1'b0;
        next_s.cnt[i] = 5'h00;
        next_s.dly[i] = s.phase[i];
      end else if (s.dly[i] != 4'h0) begin
        // phase offset countdown before the first edge
        next_s.out[i] = 1'b0;
        next_s.dly[i] = s.dly[i] - 4'h1;
      end else begin
        // high for floor(N/2) clocks of every N
        next_s.out[i] = (s.cnt[i] < s.ratio[i][5:1]);
        if ({1'b0, s.cnt[i]} >= s.ratio[i] - 6'h01) begin
          next_s.cnt[i] = 5'h00;
        end else begin
          next_s.cnt[i] = s.cnt[i] + 5'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s            <= '0;
      s.sync_pipe  <= RST_SYNC_PIPE;
      s.sync_q     <= 1'b0;
      s.strap_pipe <= {3{RST_STRAP}};
      s.strap_q    <= RST_STRAP;
      s.st         <= st_hold;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------------
  // outputs, straight from the state record
  // ------------------------------------------------------------------
  assign o_first_clock_output  = s.out[0];
  assign o_second_clock_output = s.out[1];
  assign o_third_clock_output  = s.out[2];
  assign o_first_standard      = s.mode[0];
  assign o_second_standard     = s.mode[1];
  assign o_third_standard      = s.mode[2];
  assign o_third_delay_range   = s.range;
  assign o_third_fine_delay    = s.fine;
  assign o_third_delay_ps      = s.delay_ps;
  assign o_aligned_run         = s.run;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------

  // a held, enabled divider that is not bypassed stays low through the hold
  hold_static_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.st == st_hold && s.mode[1] != STD_OFF && s.ratio[1] != RATIO_BYPASS)
      |=> !o_second_clock_output)
    else $error("held divider output not static low");

  // release waits exactly four clocks before the run state
  release_wait_a: assert property (
    @(posedge i_clk) disable iff (i_rst || !s.sync_q)
    (s.st == st_hold && s.sync_q) |=> (s.st == st_wait) [*4] ##1 (s.st == st_run))
    else $error("restart not four clocks after release");

  // a bypassed output keeps toggling whatever the sequencer does
  bypass_toggle_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.mode[0] != STD_OFF && s.ratio[0] == RATIO_BYPASS)
      |=> (o_first_clock_output != $past(o_first_clock_output)))
    else $error("bypassed output stopped following the clock");

  // a switched-off output is held low
  disabled_low_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.mode[2] == STD_OFF) |=> !o_third_clock_output)
    else $error("disabled output not low");

  // while the phase countdown runs no edge is produced
  phase_wait_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.st == st_run && s.dly[1] != 4'h0 && s.mode[1] != STD_OFF
      && s.ratio[1] != RATIO_BYPASS) |=> !o_second_clock_output)
    else $error("edge before phase offset elapsed");

  // with a zero phase offset the first edge comes at once after the wait
  first_edge_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.st == st_hold ##1 (s.st == st_wait) [*4] ##1 s.st == st_run && s.dly[1] == 4'h0
      && s.mode[1] != STD_OFF && s.ratio[1] != RATIO_BYPASS && s.sync_q)
      |=> o_second_clock_output)
    else $error("no first edge after zero phase offset");

  // usage 0 switches the third output off
  usage_off_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.strap_q[5:4] == LVL_ZERO && !s.strap_q[24]) |=> (s.mode[2] == STD_OFF))
    else $error("third output not off for usage 0");

  // pair c on usage 2/3 picks the alternate third divide
  alt_divide_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.strap_q[5:4] == LVL_TWO3 && !s.strap_q[24] && s.strap_q[32:31] == 2'h0)
      |=> (s.ratio[2] == ALT_TABLE[$past(s.strap_q[21:18])]))
    else $error("alternate third divide wrong");

  // pair c on usage 1/3 gives the first divide from the main table
  main_divide_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.strap_q[5:4] == LVL_THIRD && !s.strap_q[24] && s.strap_q[32:31] == 2'h0)
      |=> (s.ratio[0] == DIV_TABLE[$past(s.strap_q[21:18])]))
    else $error("first divide wrong");

  // an open strap pin reads as the self-bias level
  open_strap_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.strap_q[24] && s.strap_q[23:22] == 2'h0)
      |=> ({s.mode[0], s.mode[1], s.mode[2]}
           == MODE_TABLE[{LVL_THIRD, $past(s.strap_q[3:2])}]))
    else $error("open usage strap not read as one third");

  // pair a sets the second phase when usage is 0
  second_phase_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.strap_q[5:4] == LVL_ZERO && s.strap_q[32:22] == 11'h000)
      |=> (s.phase[1] == $past(s.strap_q[13:10])))
    else $error("second phase not from pair a");

  // pair b sets the third phase on usage 1 with a delay range
  third_phase_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.strap_q[5:4] == LVL_ONE && s.strap_q[1:0] != LVL_ZERO && s.strap_q[32:22] == 11'h000)
      |=> (s.phase[2] == $past(s.strap_q[17:14])))
    else $error("third phase not from pair b");

  // a bypassed delay hands the fine pair to the third phase
  fine_phase_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.strap_q[1:0] == LVL_ZERO && s.strap_q[32:22] == 11'h000)
      |=> (s.phase[2] == $past(s.strap_q[9:6]) && s.delay_ps == 14'h0000))
    else $error("bypassed delay not used as phase");

  // usage 2/3 switches the first output off
  first_off_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.strap_q[5:4] == LVL_TWO3 && !s.strap_q[24]) |=> (s.mode[0] == STD_OFF))
    else $error("first output not off for usage 2/3");

  // usage 1 switches the second output off
  second_off_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.strap_q[5:4] == LVL_ONE && !s.strap_q[24]) |=> (s.mode[1] == STD_OFF))
    else $error("second output not off for usage 1");

  // a bypassed second output keeps toggling as well
  bypass_second_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.mode[1] != STD_OFF && s.ratio[1] == RATIO_BYPASS)
      |=> (o_second_clock_output != $past(o_second_clock_output)))
    else $error("bypassed second output stopped");

  // an accepted request sends wait or run back to hold
  request_hold_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (s.st != st_hold && !s.sync_q) |=> (s.st == st_hold && !o_aligned_run))
    else $error("request did not return to hold");

endmodule : clock_divider_sync_setup

// ==== clock_consumer.sv ====
// converter model: measures period, high time and rises of one divided clock
`timescale 1ns/1ns
module clock_consumer (
  input  wire logic   i_clk,    // input clock that the dividers count
  input  wire logic   i_rst,    // clears the measurements
  input  wire logic   i_clk_in, // divided clock taken as encode clock
  output logic [7:0]  o_period, // clocks between the last two rises
  output logic [7:0]  o_high,   // clocks high in the last pulse
  output logic [15:0] o_rises   // rising edges seen since reset
);
  logic       last; // previous sample of the divided clock
  logic [7:0] cnt;  // clocks since the last rise
  logic [7:0] hcnt; // clocks high in the current pulse

  // sample on the input clock, as an encode stage would
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last     <= 1'b0;
      cnt      <= 8'h00;
      hcnt     <= 8'h00;
      o_period <= 8'h00;
      o_high   <= 8'h00;
      o_rises  <= 16'h0000;
    end else begin
      last <= i_clk_in;
      if (i_clk_in && !last) begin // rise closes a period
        o_period <= cnt;
        o_rises  <= o_rises + 16'h0001;
        cnt      <= 8'h01;
        hcnt     <= 8'h01;
      end else begin
        cnt <= cnt + 8'h01;
        if (i_clk_in) hcnt <= hcnt + 8'h01;
        if (!i_clk_in && last) o_high <= hcnt; // fall closes a pulse
      end
    end
  end
endmodule : clock_consumer

// ==== clock_divider_sync_setup_test.sv ====
// self-checking bench for the strap-configured clock divider
`timescale 1ns/1ns
module clock_divider_sync_setup_test;
  import clkdiv_pkg::*;
  // ----------------------------------------------------------------
  // signals and expectation tables
  // ----------------------------------------------------------------
  logic        i_clk = 1'b0;        // 25 MHz input clock
  logic        i_rst = 1'b1;        // power-on event
  logic        sync_n = 1'b1;       // request, high in normal use
  logic [1:0]  s [11];              // strap levels in pin order
  logic [10:0] open_mask = 11'h000; // straps left open
  logic        o1, o2, o3, run;     // divided clocks, running flag
  logic [1:0]  std1, std2, std3;    // decoded standards
  logic [1:0]  rng;                 // decoded range
  logic [3:0]  fine;                // decoded fine delay
  logic [13:0] dps;                 // decoded delay in ps
  logic [7:0]  per [3];             // measured periods
  logic [7:0]  hi [3];              // measured high times
  logic [15:0] rises [3];           // rising edges per output
  int          n_fail = 0;          // mismatches
  int          cmp_count = 0;       // comparisons
  int          cycles = 0;          // watchdog count
  integer      seed = 32'hb23b91b5; // fixed seed
  int div_tab [16] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 12, 15, 16, 18, 24, 30, 32};
  int alt_tab [16] = '{7, 11, 13, 14, 17, 19, 20, 21, 22, 23, 25, 26, 27, 28, 29, 31};
  // {first, second, third} standard by usage*4+standard
  logic [5:0] mode_tab [16] = '{6'h04, 6'h28, 6'h14, 6'h18, 6'h2a, 6'h15, 6'h16, 6'h29,
                                6'h00, 6'h01, 6'h02, 6'h08, 6'h12, 6'h21, 6'h11, 6'h22};
  int fs_ps [4] = '{0, 1800, 6000, 11600};

  clock_divider_sync_setup uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_sync_request_n(sync_n),
    .i_delay_range_pin(s[0]), .i_output_standard_pin(s[1]), .i_output_usage_pin(s[2]),
    .i_fine_delay_low_pin(s[3]), .i_fine_delay_high_pin(s[4]),
    .i_shared_setting_a_low(s[5]), .i_shared_setting_a_high(s[6]),
    .i_shared_setting_b_low(s[7]), .i_shared_setting_b_high(s[8]),
    .i_shared_setting_c_low(s[9]), .i_shared_setting_c_high(s[10]),
    .i_strap_open(open_mask), .o_first_clock_output(o1), .o_second_clock_output(o2),
    .o_third_clock_output(o3), .o_first_standard(std1), .o_second_standard(std2),
    .o_third_standard(std3), .o_third_delay_range(rng), .o_third_fine_delay(fine),
    .o_third_delay_ps(dps), .o_aligned_run(run));
  clock_consumer c1 (.i_clk(i_clk), .i_rst(i_rst), .i_clk_in(o1), .o_period(per[0]),
                     .o_high(hi[0]), .o_rises(rises[0]));
  clock_consumer c2 (.i_clk(i_clk), .i_rst(i_rst), .i_clk_in(o2), .o_period(per[1]),
                     .o_high(hi[1]), .o_rises(rises[1]));
  clock_consumer c3 (.i_clk(i_clk), .i_rst(i_rst), .i_clk_in(o3), .o_period(per[2]),
                     .o_high(hi[2]), .o_rises(rises[2]));

  // ----------------------------------------------------------------
  // clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial forever #20 i_clk = ~i_clk;

  // cuts a hang short
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : chk

  function automatic int rnd16();
    return $unsigned($random(seed)) % 16;
  endfunction : rnd16

  // drives a base-4 pin pair, low digit first
  task automatic put_code(input int lo, input int code);
    s[lo]     <= 2'(code % 4);
    s[lo + 1] <= 2'(code / 4);
  endtask : put_code

  // lets the strap pipeline land, then samples mid-cycle
  task automatic settle();
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
  endtask : settle

  // holds the request low well past 5 ns, releases, times the restart
  task automatic sync_pulse(output int t_run, output int t [3], output int tog,
                            output logic [3:0] seen);
    logic last1;
    t_run = 0;
    t     = '{0, 0, 0};
    tog   = 0;
    seen  = 4'h0;
    @(posedge i_clk);
    sync_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    last1 = o1;
    repeat (12) begin
      @(negedge i_clk);
      tog  += (o1 !== last1);
      last1 = o1;
      seen |= {run, o3, o2, o1};
    end
    @(posedge i_clk);
    sync_n <= 1'b1;
    for (int k = 1; k <= 80; k++) begin
      @(negedge i_clk);
      if (t_run == 0 && run === 1'b1) t_run = k;
      if (t[0] == 0 && o1 === 1'b1) t[0] = k;
      if (t[1] == 0 && o2 === 1'b1) t[1] = k;
      if (t[2] == 0 && o3 === 1'b1) t[2] = k;
    end
  endtask : sync_pulse

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int u, a, b, c, r, f, st, t_run, tog;
    int t [3];
    int nx [3];
    int px [3];
    logic [3:0]  seen;
    logic [15:0] r0 [3];
    logic [5:0]  m;
    for (int k = 0; k < 11; k++) s[k] <= 2'h1;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(negedge i_clk);
    chk(run, 1'b0, "running before alignment");
    repeat (20) @(negedge i_clk);
    chk(run, 1'b1, "power-on alignment");
    chk(rises[0] > 0, 1, "no output after power-on");
    // every standard and usage pair
    for (int k = 0; k < 16; k++) begin
      @(posedge i_clk);
      s[1] <= 2'(k % 4);
      s[2] <= 2'(k / 4);
      settle();
      chk({std1, std2, std3}, mode_tab[k], "standards");
    end
    // an open usage strap reads as 1/3
    @(posedge i_clk);
    s[1]      <= 2'h1;
    s[2]      <= 2'h0;
    open_mask <= 11'h004;
    settle();
    chk({std1, std2, std3}, mode_tab[5], "open strap");
    // delay range and fine fraction, maximum code first
    for (int k = 0; k < 8; k++) begin
      r = k % 4;
      f = (k < 4) ? 15 : rnd16();
      @(posedge i_clk);
      open_mask <= 11'h000;
      s[0] <= 2'(r);
      put_code(3, f);
      settle();
      chk(rng, r, "range");
      chk(fine, (r == 0) ? 0 : f, "fine delay");
      chk(dps, fs_ps[r] * f / 16, "delay ps");
    end
    // ratios, phases and sync across all usages
    for (int it = 0; it < 12; it++) begin
      u  = it % 4;
      a  = (it == 0) ? 15 : rnd16();
      b  = (it == 0) ? 0 : rnd16();
      c  = (it == 0) ? 15 : rnd16();
      r  = rnd16() % 4;
      f  = rnd16();
      st = (u == 0) ? 2 : (u == 2) ? 1 : rnd16() % 4;
      @(posedge i_clk);
      s[0] <= 2'(r);
      s[1] <= 2'(st);
      s[2] <= 2'(u);
      put_code(3, f);
      put_code(5, a);
      put_code(7, b);
      put_code(9, c);
      settle();
      m     = mode_tab[u * 4 + st];
      nx[0] = div_tab[c];
      nx[1] = div_tab[b];
      nx[2] = (u == 2) ? alt_tab[c] : div_tab[a];
      px[0] = 0;
      px[1] = (u == 0) ? a : 0;
      px[2] = (r == 0) ? f : (u == 3) ? b : 0;
      for (int i = 0; i < 3; i++) r0[i] = rises[i];
      sync_pulse(t_run, t, tog, seen);
      chk(t_run, 10, "restart delay");
      chk(seen[3], 1'b0, "running during hold");
      for (int i = 0; i < 3; i++) begin
        if (m[5 - 2 * i -: 2] == 2'h0) begin
          chk(rises[i] - r0[i], 0, "disabled output moved");
        end else if (nx[i] == 1) begin
          chk(per[i], 2, "bypass period");
          chk(hi[i], 1, "bypass high");
        end else begin
          chk(per[i], nx[i], "divide period");
          chk(hi[i], nx[i] / 2, "high time");
          chk(seen[i], 1'b0, "not frozen");
          chk(t[i], 11 + px[i], "first edge");
        end
      end
      if (nx[0] == 1 && m[5:4] != 2'h0) chk(tog >= 10, 1, "bypass frozen");
    end
    // a second request during the wait restarts the hold
    @(posedge i_clk);
    sync_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    sync_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    sync_n <= 1'b0;
    seen = 4'h0;
    repeat (15) begin
      @(negedge i_clk);
      seen[3] |= run;
    end
    chk(seen[3], 1'b0, "ran despite resync");
    @(posedge i_clk);
    sync_n <= 1'b1;
    repeat (12) @(negedge i_clk);
    chk(run, 1'b1, "no restart after resync");
    give_verdict();
  end
endmodule : clock_divider_sync_setup_test
